// ---- inc/dsg_consts.svh ----
/*
 * constants of the debug security gate: field positions, encodings, counts.
 * assumes inclusion by bare name from the package and the design files.
 */
`ifndef DSG_CONSTS_SVH
`define DSG_CONSTS_SVH
// ----------------------------------------------------------------
// security copy field
// ----------------------------------------------------------------
`define DSG_SEC_LSB        0
`define DSG_SEC_MSB        1
`define DSG_SEC_OPEN       2'h2
`define DSG_SEC_RESET      2'h3
// ----------------------------------------------------------------
// mass erase enable field
// ----------------------------------------------------------------
`define DSG_MASS_ERASE_ENABLE_FIELD_LSB       2
`define DSG_MASS_ERASE_ENABLE_FIELD_MSB       3
`define DSG_MASS_ERASE_ENABLE_FIELD_OFF       2'h2
// ----------------------------------------------------------------
// debug control word
// ----------------------------------------------------------------
`define DSG_CTL_ERASE_BIT  0
`define DSG_CMD_ERASE_ALL  4'h8
`define DSG_NUM_BKPT       2
`define DSG_NUM_WPT        2
`endif

// ---- inc/dsg_pkg.sv ----
/*
 * types of the debug security gate.
 * assumes dsg_consts.svh is on the include path.
 */
`include "dsg_consts.svh"
package dsg_pkg;
    // loader states, one-hot
    typedef enum logic [2:0] {
        DSG_LD_IDLE = 3'h1,
        DSG_LD_READ = 3'h2,
        DSG_LD_DONE = 3'h4
    } dsg_ld_t;
endpackage

// ---- inc/dsg_sec_if.sv ----
/*
 * security state carried from the loader to the gate.
 * assumes both ends share sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface dsg_sec_if;
    logic       loaded;     // security state valid
    logic [1:0] secField;   // security copy
    logic [1:0] meenField;  // mass erase enable copy
    modport loader (output loaded, output secField, output meenField);
    modport gate   (input loaded, input secField, input meenField);
endinterface
`default_nettype wire

// ---- core/dsg_sec_loader.sv ----
/*
 * loads the security byte from the configuration area after reset.
 * assumes the configuration read answers with cfgValid one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsg_consts.svh"
module dsg_sec_loader
    import dsg_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    output logic            cfgRead,
    input  wire logic       cfgValid,
    input  wire logic [7:0] cfgByte,
    dsg_sec_if.loader       sec
);
    dsg_ld_t state_r;  // loader state
    // ----------------------------------------------------------------
    // load sequence
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r       <= DSG_LD_IDLE;
            cfgRead       <= 1'b0;
            sec.loaded    <= 1'b0;
            // secured until loaded, the safe side
            sec.secField  <= `DSG_SEC_RESET;
            sec.meenField <= `DSG_MASS_ERASE_ENABLE_FIELD_OFF;
        end else begin
            case (state_r)
                DSG_LD_IDLE: begin
                    cfgRead <= 1'b1;
                    state_r <= DSG_LD_READ;
                end
                DSG_LD_READ: begin
                    cfgRead <= 1'b0;
                    if (cfgValid) begin   // RULE_01
                        sec.secField  <= cfgByte[`DSG_SEC_MSB:`DSG_SEC_LSB];
                        sec.meenField <= cfgByte[`DSG_MASS_ERASE_ENABLE_FIELD_MSB:`DSG_MASS_ERASE_ENABLE_FIELD_LSB];
                        sec.loaded    <= 1'b1;
                        state_r       <= DSG_LD_DONE;
                    end
                end
                DSG_LD_DONE: state_r <= DSG_LD_DONE;
                default:     state_r <= DSG_LD_IDLE;
            endcase
        end
    end
    property load_once;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(sec.loaded) |-> $past(cfgValid);
    endproperty
    load_gate_a: assert property (load_once) // RULE_01
        else $error("security loaded without config data");
endmodule
`default_nettype wire

// ---- core/dsg_gate.sv ----
/*
 * debug security gate: decides what the serial wire debug port may do.
 * assumes the debug access port delivers decoded requests, one-cycle pulses.
 */
//
// Functional notes
// RULE_01 - security state loaded from config at reset
// RULE_02 - only debug accesses are restricted
// RULE_03 - unsecured: all flash commands accepted
// RULE_04 - secured 00/01/11: only mass erase passes
// RULE_05 - secured: debug memory access denied
// RULE_06 - debugger may write mass erase bit
// RULE_07 - mass erase ignores region protection
// RULE_08 - mass erase disabled blocks debugger erase
// RULE_09 - run/halt, two breakpoints, two watchpoints
// RULE_10 - serial wire debug is sole port
// RULE_11 - erase bit 0, cleared on done
// RULE_12 - control reachable only via debug port
// RULE_13 - encoding 10 means unsecured
`timescale 1ns/1ps
`default_nettype none
`include "dsg_consts.svh"
module dsg_gate
    import dsg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    output logic             cfgRead,
    input  wire logic        cfgValid,
    input  wire logic [7:0]  cfgByte,
    input  wire logic        dbgMemReq,
    input  wire logic        dbgCtlWrite,
    input  wire logic [31:0] dbgCtlData,
    input  wire logic        dbgCmdReq,
    input  wire logic [3:0]  dbgCmd,
    input  wire logic        cpuCmdReq,
    input  wire logic [3:0]  cpuCmd,
    input  wire logic        eraseDone,
    input  wire logic        dbgHaltReq,
    input  wire logic [31:0] pcAddr,
    input  wire logic [31:0] dataAddr,
    input  wire logic [31:0] bkptAddr0,
    input  wire logic [31:0] bkptAddr1,
    input  wire logic [31:0] wptAddr0,
    input  wire logic [31:0] wptAddr1,
    output logic             memGrant,
    output logic             memDeny,
    output logic             flashCmdGo,
    output logic [3:0]       flashCmd,
    output logic             flashCmdReject,
    output logic             eraseIgnoreProt,
    output logic             eraseBit,
    output logic             secured,
    output logic             coreHalt,
    output logic [1:0]       bkptHit,
    output logic [1:0]       wptHit
);
    // ----------------------------------------------------------------
    // security state
    // ----------------------------------------------------------------
    dsg_sec_if secBus ();  // loader to gate
    logic      isSecured;  // current decode
    logic      eraseOk;    // mass erase permitted
    logic      eraseWr;    // debugger asks for erase
    logic [31:0] cmpAddr [0:3];  // comparator targets
    logic [31:0] cmpVal  [0:3];  // comparator inputs
    logic [3:0]  hit;            // comparator matches

    dsg_sec_loader u_loader (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .cfgRead  (cfgRead),
        .cfgValid (cfgValid),
        .cfgByte  (cfgByte),
        .sec      (secBus.loader)
    );

    // before load the gate reads secured, so nothing leaks early
    always_comb begin
        // only 10 opens the part
        isSecured = !secBus.loaded
                    || (secBus.secField != `DSG_SEC_OPEN); // RULE_13
        eraseOk   = secBus.loaded && (secBus.meenField != `DSG_MASS_ERASE_ENABLE_FIELD_OFF);
        // control is only written from the debug port side
        eraseWr   = dbgCtlWrite && dbgCtlData[`DSG_CTL_ERASE_BIT]; // RULE_12
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            secured <= 1'b1;
        end else begin
            secured <= isSecured;
        end
    end

    // ----------------------------------------------------------------
    // debug memory gate
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            memGrant <= 1'b0;
            memDeny  <= 1'b0;
        end else begin
            memGrant <= dbgMemReq && !isSecured; // RULE_05
            memDeny  <= dbgMemReq && isSecured;  // RULE_05
        end
    end

    // ----------------------------------------------------------------
    // mass erase request bit
    // ----------------------------------------------------------------
    // a blocked request stays set until reset; done clears only if allowed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            eraseBit <= 1'b0;
        end else if (eraseWr) begin
            eraseBit <= 1'b1;             // RULE_06
        end else if (eraseDone && eraseOk) begin
            eraseBit <= 1'b0;             // RULE_11
        end
    end

    // ----------------------------------------------------------------
    // flash command arbitration
    // ----------------------------------------------------------------
    // priority: debugger erase, then cpu, then debug command
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flashCmdGo      <= 1'b0;
            flashCmd        <= 4'h0;
            flashCmdReject  <= 1'b0;
            eraseIgnoreProt <= 1'b0;
        end else begin
            flashCmdGo      <= 1'b0;
            flashCmdReject  <= 1'b0;
            eraseIgnoreProt <= 1'b0;
            if (eraseWr && !eraseBit) begin
                if (eraseOk) begin        // RULE_08
                    flashCmdGo      <= 1'b1;           // RULE_06
                    flashCmd        <= `DSG_CMD_ERASE_ALL;
                    eraseIgnoreProt <= 1'b1;           // RULE_07
                end else begin
                    flashCmdReject  <= 1'b1;           // RULE_08
                end
            end else if (cpuCmdReq) begin
                flashCmdGo <= 1'b1;       // RULE_02
                flashCmd   <= cpuCmd;
            end else if (dbgCmdReq) begin
                if (!isSecured) begin
                    flashCmdGo <= 1'b1;   // RULE_03
                    flashCmd   <= dbgCmd;
                end else begin
                    flashCmdReject <= 1'b1; // RULE_04
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // run control and comparators
    // ----------------------------------------------------------------
    // halt and comparators belong to the debug session, closed when secured
    always_comb begin
        cmpAddr[0] = bkptAddr0;
        cmpAddr[1] = bkptAddr1;
        cmpAddr[2] = wptAddr0;
        cmpAddr[3] = wptAddr1;
        cmpVal[0]  = pcAddr;
        cmpVal[1]  = pcAddr;
        cmpVal[2]  = dataAddr;
        cmpVal[3]  = dataAddr;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `DSG_NUM_BKPT + `DSG_NUM_WPT; gi++) begin : g_cmp
            assign hit[gi] = !isSecured
                             && (cmpVal[gi] == cmpAddr[gi]); // RULE_09
        end
    endgenerate

    // serial wire debug is the only source of these requests
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            coreHalt <= 1'b0;
            bkptHit  <= 2'h0;
            wptHit   <= 2'h0;
        end else begin
            coreHalt <= !isSecured && (dbgHaltReq || (|hit)); // RULE_10
            bkptHit  <= hit[1:0];  // RULE_09
            wptHit   <= hit[3:2];  // RULE_09
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence erase_ask;
        eraseWr && !eraseBit && eraseOk;
    endsequence
    sequence erase_launch;
        flashCmdGo && (flashCmd == `DSG_CMD_ERASE_ALL) && eraseIgnoreProt;
    endsequence

    erase_go_a: assert property ( // RULE_06
        @(posedge sys_clk) disable iff (!rst_n)
        erase_ask |=> erase_launch)
        else $error("mass erase not launched");
    // only a first write counts: with the bit set a cpu command may pass
    erase_block_a: assert property ( // RULE_08
        @(posedge sys_clk) disable iff (!rst_n)
        (eraseWr && !eraseBit && !eraseOk) |=> !flashCmdGo && eraseBit)
        else $error("disabled mass erase went through");
    mem_deny_a: assert property ( // RULE_05
        @(posedge sys_clk) disable iff (!rst_n)
        (dbgMemReq && isSecured) |=> memDeny && !memGrant)
        else $error("secured memory access granted");
    cmd_reject_a: assert property ( // RULE_04
        @(posedge sys_clk) disable iff (!rst_n)
        (dbgCmdReq && isSecured && !cpuCmdReq && !eraseWr)
        |=> flashCmdReject && !flashCmdGo)
        else $error("secured debug command accepted");
    cmd_open_a: assert property ( // RULE_03
        @(posedge sys_clk) disable iff (!rst_n)
        (dbgCmdReq && !isSecured && !cpuCmdReq && !eraseWr)
        |=> flashCmdGo && flashCmd == $past(dbgCmd))
        else $error("open debug command dropped");
    cpu_pass_a: assert property ( // RULE_02
        @(posedge sys_clk) disable iff (!rst_n)
        (cpuCmdReq && !eraseWr) |=> flashCmdGo && flashCmd == $past(cpuCmd))
        else $error("cpu command blocked");
    bit_clear_a: assert property ( // RULE_11
        @(posedge sys_clk) disable iff (!rst_n)
        (eraseBit && eraseDone && eraseOk && !eraseWr) |=> !eraseBit)
        else $error("erase bit not cleared");
    bit_hold_a: assert property ( // RULE_11
        @(posedge sys_clk) disable iff (!rst_n)
        (eraseBit && !eraseOk) |=> eraseBit)
        else $error("blocked erase bit dropped");
    open_code_a: assert property ( // RULE_13
        @(posedge sys_clk) disable iff (!rst_n)
        (secBus.loaded && secBus.secField == `DSG_SEC_OPEN) |=> !secured)
        else $error("encoding 10 not unsecured");
endmodule
`default_nettype wire

// ---- verif/dsg_probe_model.sv ----
/*
 * behavioural serial wire debug probe, seen after the access port decode.
 * assumes requests are taken on the rising edge of sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module dsg_probe_model (
    input  wire logic        sys_clk,
    output logic             dbgMemReq,
    output logic             dbgCtlWrite,
    output logic [31:0]      dbgCtlData,
    output logic             dbgCmdReq,
    output logic [3:0]       dbgCmd
);
    // ----------------------------------------------------------------
    // one request: 0 memory, 1 control write, 2 flash command
    // ----------------------------------------------------------------
    // the control path is the only way in, no memory-mapped alias
    task automatic pulse(input int kind, input logic [31:0] val);
        @(posedge sys_clk);
        dbgMemReq   <= (kind == 0);
        dbgCtlWrite <= (kind == 1);
        dbgCtlData  <= val;
        dbgCmdReq   <= (kind == 2);
        dbgCmd      <= val[3:0];
        @(posedge sys_clk);
        // released lines show the inverse, never a stale match
        dbgMemReq   <= 1'b0;
        dbgCtlWrite <= 1'b0;
        dbgCmdReq   <= 1'b0;
        dbgCtlData  <= ~val;
        dbgCmd      <= ~val[3:0];
    endtask

    initial begin
        dbgMemReq   = 1'b0;
        dbgCtlWrite = 1'b0;
        dbgCtlData  = 32'h0;
        dbgCmdReq   = 1'b0;
        dbgCmd      = 4'h0;
    end
endmodule
`default_nettype wire

// ---- verif/dsg_gate_tb_top.sv ----
/*
 * self-checking bench of the debug security gate over all security states.
 * assumes dsg_consts.svh on the include path and the probe model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsg_consts.svh"
module dsg_gate_tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, cfgValid = 1'b0, eraseDone = 1'b0;
    logic [7:0] cfgByte = 8'h0, cfgSet = 8'h0;
    logic cpuCmdReq = 1'b0, dbgHaltReq = 1'b0;
    logic [3:0] cpuCmd = 4'h0;
    logic [31:0] pcAddr = 32'h0, dataAddr = 32'h0;
    logic [31:0] bkptAddr0 = 32'h0, bkptAddr1 = 32'h0;
    logic [31:0] wptAddr0 = 32'h0, wptAddr1 = 32'h0;
    wire logic cfgRead, dbgMemReq, dbgCtlWrite, dbgCmdReq, memGrant, memDeny;
    wire logic flashCmdGo, flashCmdReject, eraseIgnoreProt, eraseBit;
    wire logic secured, coreHalt;
    wire logic [31:0] dbgCtlData;
    wire logic [3:0] dbgCmd, flashCmd;
    wire logic [1:0] bkptHit, wptHit;
    logic [8:0] expQ[$];   // {grant,deny,go,reject,ignoreProt,cmd}
    int nMismatch = 0, checkCount = 0, doneCnt = 0;

    dsg_gate i_dsg_gate (.sys_clk(sys_clk), .rst_n(rst_n), .cfgRead(cfgRead),
        .cfgValid(cfgValid), .cfgByte(cfgByte), .dbgMemReq(dbgMemReq),
        .dbgCtlWrite(dbgCtlWrite), .dbgCtlData(dbgCtlData),
        .dbgCmdReq(dbgCmdReq), .dbgCmd(dbgCmd), .cpuCmdReq(cpuCmdReq),
        .cpuCmd(cpuCmd), .eraseDone(eraseDone), .dbgHaltReq(dbgHaltReq),
        .pcAddr(pcAddr), .dataAddr(dataAddr), .bkptAddr0(bkptAddr0),
        .bkptAddr1(bkptAddr1), .wptAddr0(wptAddr0), .wptAddr1(wptAddr1),
        .memGrant(memGrant), .memDeny(memDeny), .flashCmdGo(flashCmdGo),
        .flashCmd(flashCmd), .flashCmdReject(flashCmdReject),
        .eraseIgnoreProt(eraseIgnoreProt), .eraseBit(eraseBit),
        .secured(secured), .coreHalt(coreHalt), .bkptHit(bkptHit),
        .wptHit(wptHit));
    dsg_probe_model i_dsg_probe_model (.sys_clk(sys_clk),
        .dbgMemReq(dbgMemReq), .dbgCtlWrite(dbgCtlWrite),
        .dbgCtlData(dbgCtlData), .dbgCmdReq(dbgCmdReq), .dbgCmd(dbgCmd));

    // ----------------------------------------------------------------
    // clock, config store and flash erase engine
    // ----------------------------------------------------------------
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cfgValid <= cfgRead;
        cfgByte  <= cfgRead ? cfgSet : ~cfgSet;  // junk outside the answer
        if (flashCmdGo && flashCmd === `DSG_CMD_ERASE_ALL) begin
            doneCnt <= 5;                        // erase takes five cycles
        end else if (doneCnt != 0) begin
            doneCnt <= doneCnt - 1;
        end
        eraseDone <= (doneCnt == 1);
    end

    // ----------------------------------------------------------------
    // compare and report
    // ----------------------------------------------------------------
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic endSim;
        $display("Counts: %0d mismatches, %0d checks", nMismatch, checkCount);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // every result pulse takes the oldest note; an unexpected one fails
    always @(posedge sys_clk) begin
        if (rst_n && (memGrant | memDeny | flashCmdGo | flashCmdReject)) begin
            check({memGrant, memDeny, flashCmdGo, flashCmdReject,
                   eraseIgnoreProt, flashCmdGo ? flashCmd : 4'h0},
                  expQ.size() ? expQ.pop_front() : 9'h1FF);
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        nMismatch++;
        $display("Error at %0t: run did not finish", $time);
        endSim();
    end

    // ----------------------------------------------------------------
    // main sequence: every security setting, erase enable field 00 and 10
    // ----------------------------------------------------------------
    initial begin
        int seed;
        logic open, meenOff;
        logic [3:0] cmd;
        seed = 12;
        bkptAddr0 = 32'($random(seed));
        bkptAddr1 = ~bkptAddr0;
        wptAddr0 = 32'($random(seed));
        wptAddr1 = ~wptAddr0;
        for (int m = 0; m < 2; m++) for (int s = 0; s < 4; s++) begin
            meenOff = (m == 1);
            open = (2'(s) == `DSG_SEC_OPEN);
            cfgSet = {4'h0, meenOff ? `DSG_MASS_ERASE_ENABLE_FIELD_OFF : 2'h0, 2'(s)};
            @(posedge sys_clk);
            rst_n <= 1'b0;
            repeat (3) @(posedge sys_clk);
            #1 check(secured, 1'b1);
            @(posedge sys_clk);
            rst_n <= 1'b1;
            repeat (6) @(posedge sys_clk);
            #1 check(secured, !open);
            expQ.push_back(open ? 9'h100 : 9'h080);
            i_dsg_probe_model.pulse(0, 32'h0);
            cmd = 4'($random(seed)) & 4'h7;
            expQ.push_back(open ? {5'h04, cmd} : 9'h020);
            i_dsg_probe_model.pulse(2, {28'h0, cmd});
            expQ.push_back({5'h04, ~cmd});
            @(posedge sys_clk);
            cpuCmdReq <= 1'b1;
            cpuCmd <= ~cmd;
            @(posedge sys_clk);
            cpuCmdReq <= 1'b0;
            cpuCmd <= cmd;
            expQ.push_back(meenOff ? 9'h020 : 9'h058);
            i_dsg_probe_model.pulse(1, 32'($random(seed)) | 32'h1);
            @(posedge sys_clk);
            #1 check(eraseBit, 1'b1);
            repeat (12) @(posedge sys_clk);
            #1 check(eraseBit, meenOff);
            // comparators alone halt the core first, then the halt request
            @(posedge sys_clk);
            pcAddr <= bkptAddr0;
            dataAddr <= wptAddr1;
            repeat (3) @(posedge sys_clk);
            #1 check({bkptHit, wptHit}, open ? 4'h6 : 4'h0);
            check(coreHalt, open);
            // flipping one bit matches neither comparator of a pair
            @(posedge sys_clk);
            pcAddr <= bkptAddr0 ^ 32'h2;
            dataAddr <= wptAddr1 ^ 32'h2;
            dbgHaltReq <= 1'b1;
            repeat (3) @(posedge sys_clk);
            #1 check({bkptHit, wptHit}, 4'h0);
            check(coreHalt, open);
            check(9'(expQ.size()), 9'h0);
            @(posedge sys_clk);
            dbgHaltReq <= 1'b0;
        end
        endSim();
    end
endmodule
`default_nettype wire
